// *** rtl/smc_master.sv ***
// SPI master with control registers, data port, divider and shifter.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "smc_regs.svh"
module smc_master import smc_pkg::*; #(
  parameter int FIFO_AW = 4
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        dma_frame_end_i,
  input  wire logic        miso_i,
  output logic             sclk_o,
  output logic             mosi_o,
  output logic      [2:0]  cs_o,
  output logic             irq_o,
  output logic             tx_dreq_o,
  output logic             rx_dreq_o
);
  localparam logic [FIFO_AW:0] RXR_LVL = (FIFO_AW+1)'(3 << (FIFO_AW - 2));

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic        rx_level_irq_enable;
  logic        done_irq_enable;
  logic        dma_request_enable;
  logic        nine;
  logic [15:0] clock_divisor;
  logic [15:0] len;
  logic [3:0]  output_hold_count;
  logic [1:0]  miso_sync;
  smc_state_e  state;
  logic [8:0]  shreg;
  logic [8:0]  rxsh;
  logic [3:0]  bitcnt;
  logic        half;
  logic [15:0] divcnt;
  logic [3:0]  hold_cnt;
  logic [1:0]  tx_lane;
  logic [1:0]  rx_lane;
  smc_word_t   rx_acc;
  smc_word_t   rx_word;
  logic [15:0] bytes_done;
  logic [16:0] dma_words;

  smc_fifo_if #(.W(34), .AW(FIFO_AW)) txf ();
  smc_fifo_if #(.W(32), .AW(FIFO_AW)) rxf ();

  wire acc      = (read_i | write_i) & ~waitrequest_o;
  wire wr       = write_i & acc;
  wire rd       = read_i & acc;
  wire sel_cs   = (address_i == `SMC_OFS_CS);
  wire sel_fifo = (address_i == `SMC_OFS_FIFO);
  wire sel_clk  = (address_i == `SMC_OFS_CLK);
  wire sel_transfer_length = (address_i == `SMC_OFS_TRANSFER_LENGTH);
  wire sel_output_hold_delay = (address_i == `SMC_OFS_OUTPUT_HOLD_DELAY);
  wire ta       = ctrl[`SMC_CS_TA];
  wire pol      = ctrl[`SMC_CS_SELECT_POLARITY];
  wire cpol     = ctrl[`SMC_CS_CPOL];
  wire cpha     = ctrl[`SMC_CS_CPHA];
  wire [1:0] cs_sel = ctrl[1:0];
  wire miso_s   = miso_sync[1];

  wire       cfg_wr    = wr & (sel_cs | (sel_fifo & ~ta)); // RL5
  wire [7:0] ctrl_wdat = writedata_i[7:0] & ~`SMC_CLR_MASK; // RL9
  wire [1:0] clr       = cfg_wr ? writedata_i[5:4] : 2'b00; // RL9

  always_comb begin
    next_ctrl = cfg_wr ? ctrl_wdat : ctrl;
    if (dma_frame_end_i) begin
      next_ctrl[`SMC_CS_TA] = 1'b0; // RL7
    end
  end

  // Status flags derived from the FIFOs and the shifter.
  wire in_idle = (state == SMC_IDLE);
  wire done    = ta & txf.empty & in_idle; // RL4
  wire rx_needs_reading     = ta & (rxf.level >= RXR_LVL); // RL21 RL4
  wire [31:0] cs_read = {11'h000, rxf.full, rx_needs_reading, ~txf.full, ~rxf.empty,
                         done, 2'b00, nine, 2'b00, rx_level_irq_enable, done_irq_enable, dma_request_enable, ctrl};
  wire [31:0] fifo_read = dma_request_enable ? rxf.pop_data
                                : {24'h000000, rxf.pop_data[7:0]}; // RL16
  wire [31:0] rd_mux = sel_cs   ? cs_read :
                       sel_fifo ? fifo_read :
                       sel_clk  ? {16'h0000, clock_divisor} :
                       sel_transfer_length ? {16'h0000, len} :
                       sel_output_hold_delay ? {28'h0000000, output_hold_count} : 32'h00000000;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h00000000;
    end else begin
      waitrequest_o <= ~((read_i | write_i) & waitrequest_o);
      readdata_o    <= rd_mux;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin // RL24
      ctrl  <= `SMC_CTRL_RST;
      rx_level_irq_enable  <= 1'b0;
      done_irq_enable  <= 1'b0;
      dma_request_enable <= 1'b0;
      nine  <= 1'b0;
      clock_divisor  <= `SMC_CLOCK_DIVISOR_RST;
      len   <= `SMC_TRANSFER_LENGTH_RST;
      output_hold_count   <= `SMC_TOH_RST; // RL20
    end else begin
      ctrl <= next_ctrl;
      if (wr && sel_cs) begin
        rx_level_irq_enable  <= writedata_i[`SMC_CS_RX_LEVEL_IRQ_ENABLE];
        done_irq_enable  <= writedata_i[`SMC_CS_DONE_IRQ_ENABLE];
        dma_request_enable <= writedata_i[`SMC_CS_DMA_REQUEST_ENABLE];
        nine  <= writedata_i[`SMC_CS_NINE];
      end
      if (wr && sel_fifo && !ta) begin
        len <= writedata_i[31:16]; // RL5
      end else if (wr && sel_transfer_length) begin
        len <= writedata_i[15:0]; // RL19
      end
      if (wr && sel_clk) begin
        clock_divisor <= writedata_i[15:0];
      end
      if (wr && sel_output_hold_delay) begin
        output_hold_count <= writedata_i[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs and data port.

  wire tx_wr = wr & sel_fifo & ta;
  assign txf.push      = tx_wr; // RL16 RL14
  assign txf.push_data = dma_request_enable ? {2'b11, writedata_i}
                               : {2'b00, 23'h000000, writedata_i[8:0]};
  assign txf.clear     = clr[0]; // RL9
  assign rxf.clear     = clr[1]; // RL9
  assign rxf.pop       = rd & sel_fifo;

  smc_fifo #(.W(34), .AW(FIFO_AW)) u_tx (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .f       (txf)
  );

  smc_fifo #(.W(32), .AW(FIFO_AW)) u_rx (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .f       (rxf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Divider and shifter.

  wire [15:0] even_div = clock_divisor & 16'hFFFE; // RL18
  wire [15:0] half_len = (even_div == 16'h0000) ? `SMC_HALF_MAX
                                                : {1'b0, even_div[15:1]}; // RL17
  wire        tick     = (divcnt == half_len - 16'h0001);
  wire        len_ok   = ~dma_request_enable | (bytes_done < len); // RL19 RL15
  wire        start    = in_idle & ta & ~txf.empty & ~rxf.full & len_ok
                         & (clr == 2'b00); // RL10
  wire [7:0]  tx_byte  = txf.pop_data[tx_lane*8 +: 8];
  wire        last_ent = (tx_lane == txf.pop_data[33:32])
                         | (dma_request_enable & (bytes_done + 16'h0001 == len));
  wire        byte_end = (state == SMC_SHIFT) & tick & half
                         & (bitcnt == 4'h1);
  wire [7:0]  rx_byte  = rxsh[7:0];
  wire        rx_last  = ~dma_request_enable | (rx_lane == 2'b11)
                         | (bytes_done + 16'h0001 == len);
  wire [3:0]  hold_len = (output_hold_count == 4'h0) ? 4'h1 : output_hold_count; // RL20

  always_comb begin
    rx_word = rx_acc;
    rx_word[rx_lane*8 +: 8] = rx_byte;
  end

  assign txf.pop       = start & last_ent;
  assign rxf.push      = byte_end & rx_last;
  assign rxf.push_data = dma_request_enable ? rx_word : {24'h000000, rx_byte};

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !ta) begin
      state  <= SMC_IDLE;
      divcnt <= 16'h0000;
      half   <= 1'b0;
      bitcnt <= 4'h0;
    end else begin
      case (state)
        SMC_IDLE: begin
          if (start) begin
            state  <= SMC_SHIFT;
            divcnt <= 16'h0000;
            half   <= 1'b0;
            bitcnt <= nine ? 4'h9 : 4'h8; // RL22
          end
        end
        SMC_SHIFT: begin
          divcnt <= tick ? 16'h0000 : divcnt + 16'h0001;
          if (tick) begin
            half <= ~half;
            if (half) begin
              bitcnt <= bitcnt - 4'h1;
            end
          end
          if (byte_end) begin
            state <= nine ? SMC_HOLD : SMC_IDLE; // RL23
          end
        end
        SMC_HOLD: begin
          if (hold_cnt == 4'h1) begin
            state <= SMC_IDLE; // RL20
          end
        end
        default: state <= SMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      shreg    <= 9'h000;
      rxsh     <= 9'h000;
      hold_cnt <= 4'h1;
    end else if (start) begin
      shreg <= nine ? txf.pop_data[8:0] : {tx_byte, 1'b0}; // RL22
    end else if (state == SMC_SHIFT && tick) begin
      if (!half) begin
        rxsh <= {rxsh[7:0], miso_s};
      end else begin
        shreg <= {shreg[7:0], 1'b0};
      end
      hold_cnt <= hold_len;
    end else if (state == SMC_HOLD) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !ta) begin
      bytes_done <= 16'h0000;
      dma_words  <= 17'h00000;
    end else begin
      if (byte_end) begin
        bytes_done <= bytes_done + 16'h0001;
      end
      if (tx_wr && dma_request_enable && !txf.full) begin
        dma_words <= dma_words + 17'h00001; // RL14
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !ta || clr[0]) begin
      tx_lane <= 2'b00;
    end else if (start) begin
      tx_lane <= last_ent ? 2'b00 : tx_lane + 2'b01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !ta || clr[1]) begin
      rx_lane <= 2'b00;
      rx_acc  <= 32'h00000000;
    end else if (byte_end) begin
      rx_lane <= rx_last ? 2'b00 : rx_lane + 2'b01;
      rx_acc  <= rx_last ? 32'h00000000 : rx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins, interrupt and DMA requests.

  wire        in_shift  = (state == SMC_SHIFT);
  wire [16:0] words_req = ({1'b0, len} + 17'h00003) >> 2;
  wire        tx_req    = dma_request_enable & ~txf.full
                          & (~ta | (dma_words < words_req)); // RL3 RL15
  wire        rx_req    = dma_request_enable & ~rxf.empty; // RL3

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      miso_sync <= 2'b00;
      sclk_o    <= 1'b0;
      mosi_o    <= 1'b0;
      irq_o     <= 1'b0;
      tx_dreq_o <= 1'b0;
      rx_dreq_o <= 1'b0;
    end else begin
      miso_sync <= {miso_sync[0], miso_i};
      sclk_o    <= cpol ^ (in_shift & (half ^ cpha)); // RL11 RL12 RL23
      mosi_o    <= shreg[8];
      irq_o     <= (rx_level_irq_enable & rx_needs_reading) | (done_irq_enable & done); // RL1 RL2
      tx_dreq_o <= tx_req;
      rx_dreq_o <= rx_req;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cs
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          cs_o[gi] <= 1'b1;
        end else if (ta && cs_sel == 2'(gi)) begin
          cs_o[gi] <= pol; // RL6 RL8 RL13
        end else begin
          cs_o[gi] <= ~pol; // RL4 RL8
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  irq_rxr_a: assert property (rx_level_irq_enable && rx_needs_reading |=> irq_o) // RL1
    else $error("rx level interrupt missing");
  irq_done_a: assert property (done_irq_enable && done |=> irq_o) // RL2
    else $error("done interrupt missing");
  irq_quiet_a: assert property (!(rx_level_irq_enable && rx_needs_reading) && !(done_irq_enable && done)
    |=> !irq_o) else $error("spurious interrupt"); // RL1
  dreq_off_a: assert property (!dma_request_enable |=> !tx_dreq_o && !rx_dreq_o) // RL3
    else $error("dma request while disabled");
  cs_idle_a: assert property (!ta |=> cs_o == {3{!$past(pol)}}) // RL4
    else $error("select active without transfer");
  flags_idle_a: assert property (!ta |-> !done && !rx_needs_reading) // RL4
    else $error("flags set without transfer");
  cfg_load_a: assert property (wr && sel_fifo && !ta // RL5
    |=> len == $past(writedata_i[31:16])) else $error("length not loaded");
  frame_end_a: assert property (dma_frame_end_i |=> !ta) // RL7
    else $error("frame end did not clear transfer");
  tx_clear_a: assert property (wr && sel_cs && writedata_i[4] // RL9
    |=> txf.empty && ctrl[5:4] == 2'b00) else $error("tx clear failed");
  sclk_rest_a: assert property (in_idle ##1 in_idle // RL23
    |=> sclk_o == $past(cpol)) else $error("serial clock not at rest");
  wait_one_a: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("bus answer late");

  byte_cov_c: cover property (byte_end);
  nine_cov_c: cover property (byte_end && nine ##1 state == SMC_HOLD);
  dma_cov_c: cover property (tx_wr && dma_request_enable);
  irq_cov_c: cover property (irq_o && done);
endmodule // smc_master

// *** rtl/smc_regs.svh ***
// Register offsets, field positions, reset values and counts of the SPI master.
//
// What this block does
// (RL1) Receive-level interrupt enable raises the interrupt while rx_needs_reading is high.
// (RL2) Done interrupt enable raises the interrupt while the transfer-complete flag is one.
// (RL3) DMA data requests are issued only while dma_request_enable is one.
// (RL4) Without transfer_active all selects are inactive, rx_needs_reading and done read zero.
// (RL5) Data-port write without transfer_active loads length_field and control_field bits 7:0.
// (RL6) With transfer_active the selects follow the chosen index and the polarity.
// (RL7) A frame-end pulse from the DMA engine clears transfer_active.
// (RL8) select_polarity zero makes selects active low, one makes them active high.
// (RL9) The clear field empties the TX FIFO (low bit) or RX FIFO (high bit), reads zero.
// (RL10) A clear written together with transfer_active takes effect before the frame starts.
// (RL11) Clock polarity sets the idle level of the serial clock.
// (RL12) Clock phase puts the first clock edge mid-bit (zero) or at bit start (one).
// (RL13) Select index 00, 01, 10 choose outputs 0, 1, 2; 11 selects none.
// (RL14) In DMA mode data-port accesses after the configuration word move four-byte words.
// (RL15) In DMA mode word requests stop once the programmed byte length is reached.
// (RL16) In polled mode a data-port write pushes one byte, a read pops one byte.
// (RL17) Serial clock is core clock over clock_divisor; zero means 65536.
// (RL18) An odd clock_divisor is rounded down to the next even value.
// (RL19) length_field counts bytes to send and receive and acts only in DMA mode.
// (RL20) output_hold_count sets the nine-bit mode hold in clocks, zero gives one, resets to one.
// (RL21) rx_needs_reading is high while RX FIFO is three quarters full and a transfer runs.
// (RL22) Nine-bit mode prefixes each byte with a flag bit and shifts nine bits.
// (RL23) The serial clock toggles only while a byte shifts and rests otherwise.
// (RL24) All registers update on the core clock and reset to their documented values.
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

`define SMC_OFS_CS      5'h00
`define SMC_OFS_FIFO    5'h04
`define SMC_OFS_CLK     5'h08
`define SMC_OFS_TRANSFER_LENGTH    5'h0C
`define SMC_OFS_OUTPUT_HOLD_DELAY    5'h10

`define SMC_CS_RX_LEVEL_IRQ_ENABLE     10
`define SMC_CS_DONE_IRQ_ENABLE     9
`define SMC_CS_DMA_REQUEST_ENABLE    8
`define SMC_CS_TA       7
`define SMC_CS_SELECT_POLARITY    6
`define SMC_CS_CLR_RX   5
`define SMC_CS_CLR_TX   4
`define SMC_CS_CPOL     3
`define SMC_CS_CPHA     2
`define SMC_CS_NINE     13
`define SMC_CLR_MASK    8'h30

`define SMC_CTRL_RST    8'h00
`define SMC_CLOCK_DIVISOR_RST    16'h0000
`define SMC_TRANSFER_LENGTH_RST    16'h0000
`define SMC_TOH_RST     4'h1
`define SMC_HALF_MAX    16'h8000

`endif

// *** rtl/smc_pkg.sv ***
// Types shared by the SPI master modules.
package smc_pkg;

  typedef enum logic [2:0] {
    SMC_IDLE  = 3'b001,
    SMC_SHIFT = 3'b010,
    SMC_HOLD  = 3'b100
  } smc_state_e;

  typedef logic [31:0] smc_word_t;

endpackage

// *** rtl/smc_fifo_if.sv ***
// Push and pop port between the SPI master and one of its FIFOs.
`timescale 1ns/1ps
interface smc_fifo_if #(
  parameter int W  = 34,
  parameter int AW = 4
);
  logic          push;
  logic [W-1:0]  push_data;
  logic          pop;
  logic [W-1:0]  pop_data;
  logic          clear;
  logic          full;
  logic          empty;
  logic [AW:0]   level;

  modport user  (output push, push_data, pop, clear,
                 input  pop_data, full, empty, level);
  modport store (input  push, push_data, pop, clear,
                 output pop_data, full, empty, level);
endinterface // smc_fifo_if

// *** rtl/smc_fifo.sv ***
// Synchronous first-in first-out store with clear, used for TX and RX.
`timescale 1ns/1ps
module smc_fifo import smc_pkg::*; #(
  parameter int W  = 34,
  parameter int AW = 4
) (
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  smc_fifo_if.store   f
);
  localparam logic [AW:0] FULL_LVL = (AW+1)'(1 << AW);

  logic [W-1:0] mem [1 << AW];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  wire          do_push = f.push & ~f.full;
  wire          do_pop  = f.pop & ~f.empty;

  assign f.level    = wp - rp;
  assign f.full     = (f.level == FULL_LVL);
  assign f.empty    = (wp == rp);
  assign f.pop_data = mem[rp[AW-1:0]];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || f.clear) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_push) begin
        wp <= wp + 1'b1;
      end
      if (do_pop) begin
        rp <= rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wp[AW-1:0]] <= f.push_data;
    end
  end
endmodule // smc_fifo

// *** sim/smc_slave_model.sv ***
// Serial slave model that answers every byte with a fixed reply.
`timescale 1ns/1ps
module smc_slave_model #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input  wire logic       clock_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_i,
  output logic            miso_o,
  output logic      [7:0] rx_byte_o,
  output int              count_o
);
  logic       sclk_q = 1'b0;
  logic [7:0] out_q = REPLY;
  logic [7:0] in_q = 8'h00;
  logic [2:0] bit_q = 3'h0;
  logic       hold_q = 1'b0;
  logic       tog_q = 1'b0;
  wire        moved = sclk_i != sclk_q;
  wire        lead = moved && (sclk_q == cpol_i);
  wire        trail = moved && (sclk_q != cpol_i);
  wire        samp = cpha_i ? trail : lead;
  wire        shift = cpha_i ? lead : trail;
  // A deselected slave floats its line, shown here as a toggling level.
  assign miso_o = !sel_i ? tog_q : (cpha_i ? hold_q : out_q[7]);
  initial begin
    rx_byte_o = 8'h00;
    count_o = 0;
  end
  always @(posedge clock_i) begin
    sclk_q <= sclk_i;
    tog_q <= ~tog_q;
    if (!sel_i) begin
      out_q <= REPLY;
      bit_q <= 3'h0;
    end else begin
      if (shift) begin
        hold_q <= out_q[7];
        out_q <= {out_q[6:0], out_q[7]};
      end
      if (samp) begin
        in_q <= {in_q[6:0], mosi_i};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rx_byte_o <= {in_q[6:0], mosi_i};
          count_o <= count_o + 1;
        end
      end
    end
  end
endmodule // smc_slave_model

// *** sim/spi_master_control_regs_bench.sv ***
// Self-checking bench of the SPI master with a serial slave model.
`timescale 1ns/1ps
module spi_master_control_regs_bench;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [4:0]  address_i = 5'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic        dma_frame_end_i = 1'b0;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        miso_i;
  logic        sclk_o;
  logic        mosi_o;
  logic [2:0]  cs_o;
  logic        irq_o;
  logic        tx_dreq_o;
  logic        rx_dreq_o;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic [7:0]  rx_byte;
  int          rx_count;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [31:0] rd;
  always #5 clock_i = ~clock_i;
  smc_master #(.FIFO_AW(2)) smc_master_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .dma_frame_end_i(dma_frame_end_i), .miso_i(miso_i),
    .sclk_o(sclk_o), .mosi_o(mosi_o), .cs_o(cs_o), .irq_o(irq_o),
    .tx_dreq_o(tx_dreq_o), .rx_dreq_o(rx_dreq_o));
  smc_slave_model smc_slave_model_inst (
    .clock_i(clock_i), .cpol_i(cpol), .cpha_i(cpha), .sclk_i(sclk_o),
    .mosi_i(mosi_o), .sel_i(!cs_o[0]), .miso_o(miso_i),
    .rx_byte_o(rx_byte), .count_o(rx_count));
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge clock_i);
  endtask
  task wait_done;
    for (int k = 0; k < 400; k++) begin
      bus(1'b0, 5'h00, 32'h0);
      if (rd[16] === 1'b1) break;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    check("cs idle", 32'h7, {29'h0, cs_o});
    check("tx dreq", 32'h0, {31'h0, tx_dreq_o});
    bus(1'b0, 5'h00, 32'h0);
    check("control", 32'h0004_0000, rd);
    bus(1'b0, 5'h08, 32'h0);
    check("divider", 32'h0, rd);
    bus(1'b0, 5'h0C, 32'h0);
    check("length", 32'h0, rd);
    bus(1'b0, 5'h10, 32'h0);
    check("hold", 32'h1, rd);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    bus(1'b1, 5'h10, 32'h0000_0007);
    bus(1'b0, 5'h10, 32'h0);
    check("hold rw", 32'h7, rd);
    $display("Test reset finished");
  endtask
  task t_selects;
    logic [2:0] act;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        act = (s < 3) ? (3'b001 << s) : 3'b000;
        bus(1'b1, 5'h00, {24'h0, 1'b1, p[0], 4'h0, s[1:0]});
        settle;
        check("cs on", {29'h0, p[0] ? act : ~act}, {29'h0, cs_o});
        bus(1'b1, 5'h00, {25'h0, p[0], 6'h0});
        settle;
        check("cs off", {29'h0, {3{~p[0]}}}, {29'h0, cs_o});
      end
    end
    $display("Test selects finished");
  endtask
  task t_poll;
    int n;
    int h;
    bus(1'b1, 5'h08, 32'd17);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 5'h00, m << 2);
      cpol <= m[1];
      cpha <= m[0];
      bus(1'b1, 5'h00, 32'h280 | (m << 2));
      settle;
      check("sclk rest", {31'h0, cpol}, {31'h0, sclk_o});
      n = rx_count;
      bus(1'b1, 5'h04, 32'h0000_00A5);
      for (int k = 0; k < 400 && sclk_o === cpol; k++) @(negedge clock_i);
      h = 0;
      while (h < 400 && sclk_o !== cpol) begin
        @(negedge clock_i);
        h++;
      end
      check("half period", 32'd8, h);
      wait_done;
      settle;
      check("mosi byte", 32'hA5, {24'h0, rx_byte});
      check("byte count", n + 1, rx_count);
      check("sclk after", {31'h0, cpol}, {31'h0, sclk_o});
      check("done irq", 32'h1, {31'h0, irq_o});
      bus(1'b0, 5'h04, 32'h0);
      check("miso byte", 32'h3C, {24'h0, rd[7:0]});
      bus(1'b1, 5'h00, 32'h200);
      settle;
      check("irq off", 32'h0, {31'h0, irq_o});
    end
    bus(1'b1, 5'h00, 32'h0);
    cpol <= 1'b0;
    cpha <= 1'b0;
    $display("Test polled finished");
  endtask
  task t_level;
    bus(1'b1, 5'h00, 32'h480);
    repeat (3) bus(1'b1, 5'h04, 32'h0000_005A);
    wait_done;
    settle;
    bus(1'b0, 5'h00, 32'h0);
    check("needs read", 32'h1, {31'h0, rd[19]});
    check("level irq", 32'h1, {31'h0, irq_o});
    bus(1'b1, 5'h00, 32'h80);
    settle;
    check("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, 5'h00, 32'h480);
    bus(1'b0, 5'h04, 32'h0);
    settle;
    check("irq low", 32'h0, {31'h0, irq_o});
    bus(1'b1, 5'h00, 32'h4B0);
    bus(1'b0, 5'h00, 32'h0);
    check("after clear", 32'h0005_0480, rd);
    bus(1'b1, 5'h00, 32'h0);
    $display("Test level finished");
  endtask
  task t_dma;
    int n;
    bus(1'b1, 5'h00, 32'h100);
    settle;
    check("tx dreq", 32'h1, {31'h0, tx_dreq_o});
    bus(1'b1, 5'h04, 32'h0005_0080);
    bus(1'b0, 5'h0C, 32'h0);
    check("length", 32'h5, rd);
    bus(1'b0, 5'h00, 32'h0);
    check("control", 32'h180, {23'h0, rd[8:0]});
    n = rx_count;
    bus(1'b1, 5'h04, 32'h4433_2211);
    bus(1'b1, 5'h04, 32'h0000_0066);
    settle;
    check("tx dreq end", 32'h0, {31'h0, tx_dreq_o});
    for (int k = 0; k < 3000 && rx_count != n + 5; k++) @(negedge clock_i);
    repeat (300) @(posedge clock_i);
    check("dma bytes", n + 5, rx_count);
    check("last byte", 32'h66, {24'h0, rx_byte});
    check("rx dreq", 32'h1, {31'h0, rx_dreq_o});
    bus(1'b0, 5'h04, 32'h0);
    check("word 0", 32'h3C3C_3C3C, rd);
    bus(1'b0, 5'h04, 32'h0);
    check("word 1", 32'h0000_003C, rd);
    @(posedge clock_i);
    dma_frame_end_i <= 1'b1;
    @(posedge clock_i);
    dma_frame_end_i <= 1'b0;
    settle;
    check("cs end", 32'h7, {29'h0, cs_o});
    bus(1'b0, 5'h00, 32'h0);
    check("active", 32'h0, {31'h0, rd[7]});
    $display("Test dma finished");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_selects;
    t_poll;
    t_level;
    t_dma;
    complete_run;
  end
endmodule // spi_master_control_regs_bench
